// ===== dv/reference_monitor_output_select_test.sv
`timescale 1ns/1ps
// ==========================================================================
// testbench for the reference monitor output selector
module reference_monitor_output_select_test;
   logic clock;
   logic srst;
   logic clkEn;
   logic [rmo_pkg::SEL_W-1:0] monitorSelect;
   logic differentialMode;
   rmo_pkg::rmo_pins_t pinsIn;
   rmo_pkg::rmo_status_t statusIn;
   logic referenceMonitorOutput;
   logic levelSource;
   int edgeCount;
   int errors = 0;
   int check_count = 0;
   logic chkOn = 1'b0;
   // shadows of what the selector sampled, pins three edges back
   logic [rmo_pkg::SEL_W-1:0] selS;
   logic diffS;
   logic rstS;
   rmo_pkg::rmo_status_t stS;
   rmo_pkg::rmo_pins_t h1, h2, h3;

   rmo_monitor_select #(.SYNC_STAGES(2)) i_dut (
      .clock(clock),
      .srst(srst),
      .clkEn(clkEn),
      .monitorSelect(monitorSelect),
      .differentialMode(differentialMode),
      .pinsIn(pinsIn),
      .statusIn(statusIn),
      .referenceMonitorOutput(referenceMonitorOutput),
      .levelSource(levelSource)
   );

   rmo_board_model i_board (
      .clock(clock),
      .pins(pinsIn),
      .monitorPin(referenceMonitorOutput),
      .edgeCount(edgeCount)
   );

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // ==========================================================================
   // reference model
   function automatic logic expOut(logic [4:0] sel, logic dm, rmo_pkg::rmo_status_t s,
                                   rmo_pkg::rmo_pins_t p);
      logic v;
      logic actV;
      logic inV;
      actV = dm ? s.diffRefValid : (s.activeIsSecond ? s.secondRefValid : s.firstRefValid);
      inV = s.activeIsSecond ? s.firstRefValid : s.secondRefValid;
      case (sel[3:0])
         4'h0: v = 1'b0;
         4'h1: v = dm ? p.diffReference : p.firstReferenceInput;
         4'h2: v = dm ? 1'b0 : p.secondReferenceInput;
         4'h3: v = dm ? p.diffReference : (s.activeIsSecond ? p.secondReferenceInput
                                                            : p.firstReferenceInput);
         4'h4: v = dm ? 1'b0 : (s.activeIsSecond ? p.firstReferenceInput
                                                 : p.secondReferenceInput);
         4'h5: v = actV;
         4'h6: v = dm ? 1'b0 : inV;
         4'h7: v = s.firstRefValid;
         4'h8: v = s.secondRefValid;
         4'h9: v = s.firstRefValid & s.secondRefValid;
         4'hA: v = s.digitalLockIndication & actV & s.oscValid;
         4'hB: v = s.oscValid;
         4'hC: v = s.activeIsSecond;
         4'hD: v = ~s.digitalLockIndication;
         4'hE: v = s.holdoverActive;
         default: v = p.lockDetectPin;
      endcase
      if (sel[4] && sel[3:0] >= 4'h5 && !(dm && sel[3:0] == 4'h6)) begin
         v = ~v;
      end
      return v;
   endfunction

   always @(posedge clock) begin
      rstS <= srst;
      if (srst) begin
         h1 <= '0;
         h2 <= '0;
         h3 <= '0;
      end else if (clkEn) begin
         h1 <= pinsIn;
         h2 <= h1;
         h3 <= h2;
         selS <= monitorSelect;
         diffS <= differentialMode;
         stS <= statusIn;
      end
   end

   // ==========================================================================
   // checking and closing
   task automatic check_bit(string name, logic expV, logic gotV);
      check_count++;
      if (gotV !== expV) begin
         errors++;
         $display("wrong value %s: expected %b, seen %b", name, expV, gotV);
      end
   endtask

   task automatic close_out();
      $display("checks %0d, errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   always @(negedge clock) begin
      if (chkOn) begin
         check_bit("monitor pin", rstS ? 1'b0 : expOut(selS, diffS, stS, h3),
                   referenceMonitorOutput);
         check_bit("level class", rstS ? 1'b0 : (selS[3:0] >= 4'h5), levelSource);
      end
   end

   task automatic cyc(int n);
      repeat (n) @(posedge clock);
   endtask

   // ==========================================================================
   // scenarios
   task automatic sweep(logic dm);
      rmo_pkg::rmo_status_t pat [4];
      pat = '{7'h5C, 7'h2B, 7'h7E, 7'h35};
      differentialMode <= dm;
      for (int c = 0; c < 32; c++) begin
         for (int k = 0; k < 4; k++) begin
            monitorSelect <= c[4:0];
            statusIn <= pat[k];
            cyc(4);
         end
      end
   endtask

   task automatic ground_static();
      int e0;
      differentialMode <= 1'b0;
      monitorSelect <= 5'h10;
      cyc(3);
      e0 = edgeCount;
      cyc(20);
      check_bit("ground still", 1'b1, edgeCount == e0);
   endtask

   task automatic follow_clock();
      int e0;
      statusIn <= 7'h01;
      monitorSelect <= 5'h03;
      cyc(3);
      e0 = edgeCount;
      cyc(20);
      check_bit("clock toggles", 1'b1, edgeCount > e0);
   endtask

   task automatic back_to_back();
      statusIn <= 7'h40;
      for (int i = 0; i < 8; i++) begin
         monitorSelect <= i[0] ? 5'h17 : 5'h07;
         cyc(1);
      end
      #1 check_bit("mirror last", 1'b0, referenceMonitorOutput);
   endtask

   task automatic freeze_enable();
      statusIn <= 7'h40;
      monitorSelect <= 5'h07;
      cyc(3);
      #1 check_bit("enabled out", 1'b1, referenceMonitorOutput);
      @(posedge clock);
      clkEn <= 1'b0;
      statusIn <= 7'h00;
      monitorSelect <= 5'h08;
      cyc(4);
      #1 check_bit("frozen out", 1'b1, referenceMonitorOutput);
      @(posedge clock);
      clkEn <= 1'b1;
      cyc(2);
      #1 check_bit("resumed out", 1'b0, referenceMonitorOutput);
   endtask

   task automatic mid_reset();
      statusIn <= 7'h40;
      monitorSelect <= 5'h07;
      cyc(3);
      srst <= 1'b1;
      cyc(1);
      #1 check_bit("reset out", 1'b0, referenceMonitorOutput);
      @(posedge clock);
      srst <= 1'b0;
      cyc(3);
      #1 check_bit("after reset", 1'b1, referenceMonitorOutput);
   endtask

   // ==========================================================================
   // main sequence and watchdog
   initial begin
      srst = 1'b1;
      clkEn = 1'b1;
      monitorSelect = '0;
      differentialMode = 1'b0;
      statusIn = '0;
      cyc(2);
      srst <= 1'b0;
      cyc(2);
      chkOn <= 1'b1;
      sweep(1'b0);
      sweep(1'b1);
      ground_static();
      follow_clock();
      back_to_back();
      freeze_enable();
      mid_reset();
      close_out();
   end

   initial begin
      repeat (20000) @(posedge clock);
      errors++;
      close_out();
   end
endmodule

// ===== dv/rmo_board_model.sv
`timescale 1ns/1ps
// ==========================================================================
// board side: free-running reference clocks and lock pin, watcher on the monitor pin
module rmo_board_model (
   // clock
   input wire logic clock,
   // pins into the selector
   output rmo_pkg::rmo_pins_t pins,
   // monitor pin and its edge count
   input wire logic monitorPin,
   output int edgeCount
);
   int tick = 0;
   int edgeN = 0;
   logic lastPin = 1'b0;

   // pins stay unknown only until the first falling edge, which lies inside reset
   assign edgeCount = edgeN;

   // pins move on the falling edge at unrelated rates
   always @(negedge clock) begin
      tick <= tick + 1;
      pins.firstReferenceInput <= (tick % 6) < 3;
      pins.secondReferenceInput <= (tick % 10) < 5;
      pins.diffReference <= (tick % 4) < 2;
      pins.lockDetectPin <= (tick % 14) < 7;
   end

   // count every change seen on the monitor pin
   always @(posedge clock) begin
      lastPin <= monitorPin;
      if (monitorPin !== lastPin) begin
         edgeN <= edgeN + 1;
      end
   end
endmodule

// ===== logic/rmo_monitor_select.sv
`timescale 1ns/1ps
module rmo_monitor_select #(
   parameter int SYNC_STAGES = rmo_pkg::SYNC_STAGES_DEF
) (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   input wire logic clkEn,
   // configuration
   input wire logic [rmo_pkg::SEL_W-1:0] monitorSelect,
   input wire logic differentialMode,
   // asynchronous pins
   input wire rmo_pkg::rmo_pins_t pinsIn,
   // loop status, same clock
   input wire rmo_pkg::rmo_status_t statusIn,
   // monitor pin and source class flag
   output logic referenceMonitorOutput,
   output logic levelSource
);

   // ==========================================================================
   // elaboration check
   generate
      if (SYNC_STAGES < 2) begin : gBadSync
         $error("SYNC_STAGES must be at least 2");
      end
   endgenerate

   // ==========================================================================
   // declarations
   logic [SYNC_STAGES-1:0][rmo_pkg::PINS_W-1:0] syncQ;
   rmo_pkg::rmo_pins_t pinsSync;
   logic [rmo_pkg::CODE_W-1:0] code;
   logic mirror;
   logic selRef;
   logic unselRef;
   logic selValid;
   logic unselValid;
   logic levelRaw;
   logic dynValue;
   logic unavailable;
   logic isLevel;
   logic outD;
   logic outQ;
   logic levelQ;
   logic stepQ;

   // ==========================================================================
   // pin synchronisers
   always_ff @(posedge clock) begin
      if (srst) begin
         syncQ <= '0;
      end else if (clkEn) begin
         syncQ <= {syncQ[SYNC_STAGES-2:0], pinsIn};
      end
   end

   assign pinsSync = rmo_pkg::rmo_pins_t'(syncQ[SYNC_STAGES-1]);

   // ==========================================================================
   // select decode
   assign code = monitorSelect[rmo_pkg::CODE_W-1:0];
   assign mirror = monitorSelect[rmo_pkg::SEL_MSB];
   assign isLevel = (code >= rmo_pkg::CODE_FIRST_LEVEL);

   // loop reference, differential clock when in differential mode
   assign selRef = differentialMode ? pinsSync.diffReference :
      (statusIn.activeIsSecond ? pinsSync.secondReferenceInput
                               : pinsSync.firstReferenceInput);
   assign unselRef = !differentialMode &&
      (statusIn.activeIsSecond ? pinsSync.firstReferenceInput
                               : pinsSync.secondReferenceInput);
   assign selValid = differentialMode ? statusIn.diffRefValid :
      (statusIn.activeIsSecond ? statusIn.secondRefValid
                               : statusIn.firstRefValid);
   assign unselValid = statusIn.activeIsSecond ? statusIn.firstRefValid
                                               : statusIn.secondRefValid;

   // codes with no meaning in differential mode hold the pin low
   always_comb begin
      unavailable = 1'b0;
      case (code)
         rmo_pkg::CODE_SECOND_CLK: unavailable = differentialMode;
         rmo_pkg::CODE_UNSEL_CLK: unavailable = differentialMode;
         rmo_pkg::CODE_UNSEL_VALID: unavailable = differentialMode;
         default: unavailable = 1'b0;
      endcase
   end

   // dynamic sources
   always_comb begin
      dynValue = 1'b0;
      case (code)
         rmo_pkg::CODE_GROUND: dynValue = 1'b0;
         rmo_pkg::CODE_FIRST_CLK: begin
            dynValue = differentialMode ? pinsSync.diffReference
                                        : pinsSync.firstReferenceInput;
         end
         rmo_pkg::CODE_SECOND_CLK: dynValue = pinsSync.secondReferenceInput;
         rmo_pkg::CODE_SEL_CLK: dynValue = selRef;
         rmo_pkg::CODE_UNSEL_CLK: dynValue = unselRef;
         default: dynValue = 1'b0;
      endcase
   end

   // level sources in their active-high form
   always_comb begin
      levelRaw = 1'b0;
      case (code)
         rmo_pkg::CODE_SEL_VALID: levelRaw = selValid;
         rmo_pkg::CODE_UNSEL_VALID: levelRaw = unselValid;
         rmo_pkg::CODE_FIRST_VALID: levelRaw = statusIn.firstRefValid;
         rmo_pkg::CODE_SECOND_VALID: levelRaw = statusIn.secondRefValid;
         rmo_pkg::CODE_BOTH_VALID: begin
            levelRaw = statusIn.firstRefValid && statusIn.secondRefValid;
         end
         rmo_pkg::CODE_LOCK_ALL: begin
            levelRaw = statusIn.digitalLockIndication && selValid &&
               statusIn.oscValid;
         end
         rmo_pkg::CODE_OSC_VALID: levelRaw = statusIn.oscValid;
         rmo_pkg::CODE_ACTIVE_REF: levelRaw = statusIn.activeIsSecond;
         rmo_pkg::CODE_LOCK_LOW: levelRaw = !statusIn.digitalLockIndication;
         rmo_pkg::CODE_HOLDOVER: levelRaw = statusIn.holdoverActive;
         rmo_pkg::CODE_LD_COMPARE: levelRaw = pinsSync.lockDetectPin;
         default: levelRaw = 1'b0;
      endcase
   end

   // the top bit inverts only level sources; clocks pass unchanged
   always_comb begin
      if (unavailable) begin
         outD = 1'b0;
      end else if (isLevel) begin
         outD = levelRaw ^ mirror;
      end else begin
         outD = dynValue;
      end
   end

   // ==========================================================================
   // output registers
   always_ff @(posedge clock) begin
      if (srst) begin
         outQ <= rmo_pkg::OUT_RST;
      end else if (clkEn) begin
         outQ <= outD;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         levelQ <= rmo_pkg::CLASS_RST;
      end else if (clkEn) begin
         levelQ <= isLevel;
      end
   end

   assign referenceMonitorOutput = outQ;
   assign levelSource = levelQ;

   // ==========================================================================
   // checks
   // marks a cycle whose output was loaded on the previous edge
   always_ff @(posedge clock) begin
      if (srst) begin
         stepQ <= 1'b0;
      end else begin
         stepQ <= clkEn;
      end
   end

   ground_low_a: assert property (
      @(posedge clock) disable iff (srst)
      (clkEn && monitorSelect[3:0] == 4'h0)[*3] |=> !referenceMonitorOutput
   ) else $error("ground code did not hold the pin low");

   class_flag_a: assert property (
      @(posedge clock) disable iff (srst)
      stepQ |-> levelSource == ($past(monitorSelect[3:0]) >= 4'h5)
   ) else $error("source class flag disagrees with select code");

   first_clock_a: assert property (
      @(posedge clock) disable iff (srst)
      stepQ && $past(monitorSelect[3:0]) == 4'h1 |->
         referenceMonitorOutput == ($past(differentialMode) ?
         $past(pinsSync.diffReference) : $past(pinsSync.firstReferenceInput))
   ) else $error("first clock code routed the wrong clock");

   second_clock_a: assert property (
      @(posedge clock) disable iff (srst)
      stepQ && $past(monitorSelect[3:0]) == 4'h2 |->
         referenceMonitorOutput == (!$past(differentialMode) &&
         $past(pinsSync.secondReferenceInput))
   ) else $error("second clock code routed the wrong clock");

   selected_ref_a: assert property (
      @(posedge clock) disable iff (srst)
      stepQ && $past(monitorSelect[3:0]) == 4'h3 && !$past(differentialMode) |->
         referenceMonitorOutput == ($past(statusIn.activeIsSecond) ?
         $past(pinsSync.secondReferenceInput) : $past(pinsSync.firstReferenceInput))
   ) else $error("selected reference code routed the wrong clock");

   unselected_ref_a: assert property (
      @(posedge clock) disable iff (srst)
      stepQ && $past(monitorSelect[3:0]) == 4'h4 |->
         referenceMonitorOutput == (!$past(differentialMode) &&
         ($past(statusIn.activeIsSecond) ? $past(pinsSync.firstReferenceInput)
                                        : $past(pinsSync.secondReferenceInput)))
   ) else $error("unselected reference code routed the wrong clock");

   sel_valid_a: assert property (
      @(posedge clock) disable iff (srst)
      stepQ && $past(monitorSelect) == 5'h05 && $past(differentialMode) |->
         referenceMonitorOutput == $past(statusIn.diffRefValid)
   ) else $error("active reference status wrong in differential mode");

   unsel_valid_a: assert property (
      @(posedge clock) disable iff (srst)
      stepQ && $past(monitorSelect) == 5'h06 |->
         referenceMonitorOutput == (!$past(differentialMode) &&
         ($past(statusIn.activeIsSecond) ? $past(statusIn.firstRefValid)
                                        : $past(statusIn.secondRefValid)))
   ) else $error("inactive reference status wrong");

   first_valid_a: assert property (
      @(posedge clock) disable iff (srst)
      stepQ && $past(monitorSelect) == 5'h07 |->
         referenceMonitorOutput == $past(statusIn.firstRefValid)
   ) else $error("first reference status wrong");

   second_valid_a: assert property (
      @(posedge clock) disable iff (srst)
      stepQ && $past(monitorSelect) == 5'h08 |->
         referenceMonitorOutput == $past(statusIn.secondRefValid)
   ) else $error("second reference status wrong");

   both_valid_a: assert property (
      @(posedge clock) disable iff (srst)
      stepQ && $past(monitorSelect) == 5'h09 |->
         referenceMonitorOutput == ($past(statusIn.firstRefValid) &&
         $past(statusIn.secondRefValid))
   ) else $error("both-valid output wrong");

   lock_triple_a: assert property (
      @(posedge clock) disable iff (srst)
      stepQ && $past(monitorSelect) == 5'h0A && !$past(differentialMode) |->
         referenceMonitorOutput == ($past(statusIn.digitalLockIndication) &&
         $past(statusIn.oscValid) && ($past(statusIn.activeIsSecond) ?
         $past(statusIn.secondRefValid) : $past(statusIn.firstRefValid)))
   ) else $error("combined lock output wrong");

   osc_valid_a: assert property (
      @(posedge clock) disable iff (srst)
      stepQ && $past(monitorSelect) == 5'h0B |->
         referenceMonitorOutput == $past(statusIn.oscValid)
   ) else $error("oscillator status wrong");

   active_ref_a: assert property (
      @(posedge clock) disable iff (srst)
      stepQ && $past(monitorSelect) == 5'h0C |->
         referenceMonitorOutput == $past(statusIn.activeIsSecond)
   ) else $error("active reference level wrong");

   lock_low_a: assert property (
      @(posedge clock) disable iff (srst)
      stepQ && $past(monitorSelect) == 5'h0D |->
         referenceMonitorOutput == !$past(statusIn.digitalLockIndication)
   ) else $error("lock indication level wrong");

   holdover_a: assert property (
      @(posedge clock) disable iff (srst)
      stepQ && $past(monitorSelect) == 5'h0E |->
         referenceMonitorOutput == $past(statusIn.holdoverActive)
   ) else $error("holdover level wrong");

   comparator_a: assert property (
      @(posedge clock) disable iff (srst)
      stepQ && $past(monitorSelect) == 5'h0F |->
         referenceMonitorOutput == $past(pinsSync.lockDetectPin)
   ) else $error("comparator level wrong");

   mirror_low_a: assert property (
      @(posedge clock) disable iff (srst)
      stepQ && $past(monitorSelect) == 5'h1C |->
         referenceMonitorOutput == !$past(statusIn.activeIsSecond)
   ) else $error("mirrored active reference level wrong");

   upper_clock_a: assert property (
      @(posedge clock) disable iff (srst)
      stepQ && $past(monitorSelect) == 5'h11 && !$past(differentialMode) |->
         referenceMonitorOutput == $past(pinsSync.firstReferenceInput)
   ) else $error("upper half clock code not routed as lower half");

   sel_clock_diff_a: assert property (
      @(posedge clock) disable iff (srst)
      stepQ && $past(monitorSelect[3:0]) == 4'h3 && $past(differentialMode) |->
         referenceMonitorOutput == $past(pinsSync.diffReference)
   ) else $error("selected reference code not differential clock");

   refused_codes_a: assert property (
      @(posedge clock) disable iff (srst)
      stepQ && $past(differentialMode) && ($past(monitorSelect[3:0]) == 4'h2 ||
         $past(monitorSelect[3:0]) == 4'h4 || $past(monitorSelect[3:0]) == 4'h6) |->
         !referenceMonitorOutput
   ) else $error("unavailable code did not hold the pin low");

   sel_valid_single_a: assert property (
      @(posedge clock) disable iff (srst)
      stepQ && $past(monitorSelect) == 5'h05 && !$past(differentialMode) |->
         referenceMonitorOutput == ($past(statusIn.activeIsSecond) ?
         $past(statusIn.secondRefValid) : $past(statusIn.firstRefValid))
   ) else $error("active reference status wrong");

   lock_triple_diff_a: assert property (
      @(posedge clock) disable iff (srst)
      stepQ && $past(monitorSelect) == 5'h0A && $past(differentialMode) |->
         referenceMonitorOutput == ($past(statusIn.digitalLockIndication) &&
         $past(statusIn.oscValid) && $past(statusIn.diffRefValid))
   ) else $error("combined lock output wrong in differential mode");

   mirror_level_a: assert property (
      @(posedge clock) disable iff (srst)
      stepQ && $past(monitorSelect) == 5'h17 |->
         referenceMonitorOutput == !$past(statusIn.firstRefValid)
   ) else $error("mirrored first reference status wrong");

   reset_low_a: assert property (
      @(posedge clock)
      srst |=> !referenceMonitorOutput && !levelSource
   ) else $error("outputs not low after reset");

   freeze_a: assert property (
      @(posedge clock) disable iff (srst)
      !clkEn |=> $stable(referenceMonitorOutput) && $stable(levelSource)
   ) else $error("output moved while clock enable low");

endmodule

// ===== pkg/rmo_pkg.sv
// ==========================================================================
// constants and carriers for the reference monitor output selector
package rmo_pkg;

   // ==========================================================================
   // select field
   localparam int SEL_W = 5;
   localparam int SEL_MSB = 4;
   localparam int CODE_W = 4;

   // select codes, low four bits; the top bit mirrors level codes inverted
   localparam logic [3:0] CODE_GROUND = 4'h0;
   localparam logic [3:0] CODE_FIRST_CLK = 4'h1;
   localparam logic [3:0] CODE_SECOND_CLK = 4'h2;
   localparam logic [3:0] CODE_SEL_CLK = 4'h3;
   localparam logic [3:0] CODE_UNSEL_CLK = 4'h4;
   localparam logic [3:0] CODE_SEL_VALID = 4'h5;
   localparam logic [3:0] CODE_UNSEL_VALID = 4'h6;
   localparam logic [3:0] CODE_FIRST_VALID = 4'h7;
   localparam logic [3:0] CODE_SECOND_VALID = 4'h8;
   localparam logic [3:0] CODE_BOTH_VALID = 4'h9;
   localparam logic [3:0] CODE_LOCK_ALL = 4'hA;
   localparam logic [3:0] CODE_OSC_VALID = 4'hB;
   localparam logic [3:0] CODE_ACTIVE_REF = 4'hC;
   localparam logic [3:0] CODE_LOCK_LOW = 4'hD;
   localparam logic [3:0] CODE_HOLDOVER = 4'hE;
   localparam logic [3:0] CODE_LD_COMPARE = 4'hF;

   // first code of the level class; all codes below it are dynamic
   localparam logic [3:0] CODE_FIRST_LEVEL = CODE_SEL_VALID;

   // ==========================================================================
   // reset values and timing
   localparam logic OUT_RST = 1'b0;
   localparam logic CLASS_RST = 1'b0;
   localparam int SYNC_STAGES_DEF = 2;

   // ==========================================================================
   // carriers
   // pins from outside the clock domain
   typedef struct packed {
      logic firstReferenceInput;
      logic secondReferenceInput;
      logic diffReference;
      logic lockDetectPin;
   } rmo_pins_t;

   localparam int PINS_W = $bits(rmo_pins_t);

   // loop status from logic on the same clock
   typedef struct packed {
      logic firstRefValid;
      logic secondRefValid;
      logic diffRefValid;
      logic oscValid;
      logic digitalLockIndication;
      logic holdoverActive;
      logic activeIsSecond;
   } rmo_status_t;

endpackage
